/* hdl/gapi_pkg.sv */
// package: constants, register map and carrier types of the gauge block
// Functional notes
// - signed 16-bit charge accumulator sums current
// - accumulator saturates at limits, never wraps
// - accumulator write clears hidden fraction bits
// - auto backup after fixed accumulator step
// - restore accumulator at power-up and recall
// - accumulator write triggers nonvolatile copy
// - blank small positive samples when enabled
// - add signed bias every current sample
// - reload bias at power-up and sleep exit
// - voltage refreshed periodically, saturates high
// - snapshot holds voltage until flag cleared
// - temperature refreshed periodically, eighth degree
// - control bit one floats pin, reads level
// - control bit zero pulls pin low
// - sleep or long low releases pin
// - nonzero suspend field disables alarm path
// - suspend interrupt clears control bit
// - driver off while suspended
// - bus reset clears alarm enable
// - output select chooses data line or pin
// - data-line alarm pulls line low for a fixed time
// - pin alarm holds low until host writes one
// - alarm on accumulator or temperature thresholds
// - pending pin interrupt cleared entering suspend
package gapi_pkg;
   // ==========================================
   // register offsets (byte addresses)
   localparam logic [5:0] GAPI_OFS_STATUS = 6'h00;
   localparam logic [5:0] GAPI_OFS_SPECIAL = 6'h04;
   localparam logic [5:0] GAPI_OFS_VOLT = 6'h08;
   localparam logic [5:0] GAPI_OFS_TEMP = 6'h0c;
   localparam logic [5:0] GAPI_OFS_ACC = 6'h10;
   localparam logic [5:0] GAPI_OFS_BIAS = 6'h14;
   localparam logic [5:0] GAPI_OFS_ACC_HI = 6'h18;
   localparam logic [5:0] GAPI_OFS_ACC_LO = 6'h1c;
   localparam logic [5:0] GAPI_OFS_TEMP_HI = 6'h20;
   localparam logic [5:0] GAPI_OFS_TEMP_LO = 6'h24;
   localparam logic [5:0] GAPI_OFS_CMD = 6'h28;
   localparam logic [5:0] GAPI_OFS_NV = 6'h2c;
   // ==========================================
   // field positions
   localparam int GAPI_ST_OBE = 0;
   localparam int GAPI_ST_IOS = 1;
   localparam int GAPI_ST_SIF = 2;
   localparam int GAPI_SF_ALE = 0;
   localparam int GAPI_SF_FRZ = 1;
   localparam int GAPI_SF_PIO = 6;
   localparam int GAPI_CMD_RECALL = 0;
   localparam int GAPI_CMD_FREEZE_HOLD_FLAG = 1;
   // ==========================================
   // reset values and saturation limits
   localparam logic [15:0] GAPI_ACC_RST = 16'h0000;
   localparam logic [7:0] GAPI_BIAS_RST = 8'h00;
   localparam logic [15:0] GAPI_VOLT_MAX = 16'h7fff;
   localparam logic [15:0] GAPI_ACC_MAX = 16'h7fff;
   localparam logic [15:0] GAPI_ACC_MIN = 16'h8000;
   // ==========================================
   // accumulation scaling: sample lsb 1.5625 uV, bias lsb 1.5625 uV,
   // accumulator lsb 6.25 uVh; fraction kept in low bits
   localparam int GAPI_FRAC_W = 12;
   localparam logic [15:0] GAPI_BACKUP_STEP = 16'h0010;
   localparam logic [15:0] GAPI_BLANK_LO = 16'h000a;
   localparam logic [15:0] GAPI_BLANK_HI = 16'h0028;
   // ==========================================
   // timing
   localparam int GAPI_CLK_MHZ = 100;
   localparam int GAPI_VOLT_US = 3400;
   localparam int GAPI_TEMP_US = 220000;
   localparam int GAPI_SAMP_US = 687;
   localparam int GAPI_ALARM_LOW_US = 2000;
   localparam int GAPI_SLEEP_US = 2100000;
   localparam int GAPI_VOLT_CYC = GAPI_VOLT_US * GAPI_CLK_MHZ;
   localparam int GAPI_TEMP_CYC = GAPI_TEMP_US * GAPI_CLK_MHZ;
   localparam int GAPI_SAMP_CYC = GAPI_SAMP_US * GAPI_CLK_MHZ;
   localparam int GAPI_ALARM_LOW_CYC = GAPI_ALARM_LOW_US * GAPI_CLK_MHZ;
   localparam int GAPI_SLEEP_CYC = GAPI_SLEEP_US * GAPI_CLK_MHZ;
   // ==========================================
   // carriers
   typedef struct packed {
      logic [5:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } gapi_bus_req_t;
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } gapi_bus_rsp_t;
   typedef enum logic [3:0] {
      GAPI_PM_ACTIVE = 4'b0001,
      GAPI_PM_SUSPEND = 4'b0010,
      GAPI_PM_SLEEP = 4'b0100,
      GAPI_PM_WAKE = 4'b1000
   } gapi_pm_t;
endpackage

/* hdl/gapi_tick.sv */
// periodic one-cycle tick generator
`timescale 1ns/1ns
`default_nettype none
module gapi_tick #(
   parameter int PERIOD = 100
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // tick
   output logic tick
);
   logic [31:0] cnt_q;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 32'h0;
         tick <= 1'b0;
      end else begin
         tick <= (cnt_q == 32'(PERIOD - 1));
         cnt_q <= (cnt_q == 32'(PERIOD - 1)) ? 32'h0 : cnt_q + 32'h1;
      end
   end
endmodule // gapi_tick
`default_nettype wire

/* hdl/gapi_top.sv */
// gauge digital core: accumulator, results, pin and alarm logic
`timescale 1ns/1ns
`default_nettype none
module gapi_top
   import gapi_pkg::*;
#(
   parameter int SAMP_CYC = gapi_pkg::GAPI_SAMP_CYC,
   parameter int VOLT_CYC = gapi_pkg::GAPI_VOLT_CYC,
   parameter int TEMP_CYC = gapi_pkg::GAPI_TEMP_CYC,
   parameter int ALARM_LOW_CYC = gapi_pkg::GAPI_ALARM_LOW_CYC,
   parameter int SLEEP_CYC = gapi_pkg::GAPI_SLEEP_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // avalon-mm slave
   input wire gapi_pkg::gapi_bus_req_t bus_req,
   output gapi_pkg::gapi_bus_rsp_t bus_rsp,
   // measurement front end (same clock)
   input wire logic [15:0] cur_sample,
   input wire logic [15:0] volt_sample,
   input wire logic [10:0] temp_sample,
   // nonvolatile store (same clock)
   input wire logic [15:0] nv_acc,
   input wire logic [7:0] nv_bias,
   output logic nv_acc_copy,
   output logic [15:0] nv_acc_data,
   // power state and bus reset (same clock)
   input wire logic suspend_req,
   input wire logic sleep_req,
   input wire logic bus_reset,
   // pins
   input wire logic prog_pin_in,
   output logic prog_pin_oe_n,
   input wire logic data_line_in,
   output logic data_line_oe_n
);
   import gapi_pkg::*;

   // ==========================================
   // state
   typedef struct packed {
      logic [15:0] acc;
      logic [GAPI_FRAC_W-1:0] frac;
      logic [15:0] acc_bak;
      logic [7:0] bias;
      logic [15:0] volt;
      logic [10:0] temp;
      logic obe, irq_output_select, frz, ale, prog_io_pin_bit;
      logic [1:0] sif;
      logic [7:0] acc_hi_pend;
      logic [15:0] acc_thr_hi, acc_thr_lo;
      logic [10:0] tmp_thr_hi, tmp_thr_lo;
      logic alarm_prev;
      logic [31:0] low_cnt;
      logic long_low;
      logic [31:0] dq_cnt;
      logic dq_drv;
      gapi_pm_t pm;
      logic copy;
      logic [31:0] rdata;
      logic wait_n;
      logic pin_oe_n;
   } gapi_state_t;
   gapi_state_t s_q, s_d;

   logic samp_tick, volt_tick, temp_tick;
   logic pin_m, pin_s, dq_m, dq_s;

   gapi_tick #(.PERIOD(SAMP_CYC)) u_samp (
      .ref_clk(ref_clk), .rst(rst), .tick(samp_tick));
   gapi_tick #(.PERIOD(VOLT_CYC)) u_volt (
      .ref_clk(ref_clk), .rst(rst), .tick(volt_tick));
   gapi_tick #(.PERIOD(TEMP_CYC)) u_temp (
      .ref_clk(ref_clk), .rst(rst), .tick(temp_tick));

   // ==========================================
   // pin synchronisers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_m <= 1'b1;
         pin_s <= 1'b1;
         dq_m <= 1'b1;
         dq_s <= 1'b1;
      end else begin
         pin_m <= prog_pin_in;
         pin_s <= pin_m;
         dq_m <= data_line_in;
         dq_s <= dq_m;
      end
   end

   // ==========================================
   // next state
   logic [16+GAPI_FRAC_W:0] sum;
   logic signed [16+GAPI_FRAC_W:0] step;
   logic blank, sat_hi, sat_lo, alarm, acc_wr, wr, rd;
   logic [15:0] diff;
   logic [31:0] wd;

   always_comb begin
      s_d = s_q;
      // a write lands at the edge where waitrequest is seen low
      wr = bus_req.write && s_q.wait_n;
      rd = bus_req.read && !s_q.wait_n;
      wd = bus_req.writedata;
      acc_wr = 1'b0;
      s_d.copy = 1'b0;
      s_d.wait_n = 1'b0;
      sum = '0;
      step = '0;
      blank = 1'b0;
      sat_hi = 1'b0;
      sat_lo = 1'b0;
      diff = 16'h0;
      // accumulation: sample plus bias, fraction kept below the lsb
      if (samp_tick && s_q.pm == GAPI_PM_ACTIVE) begin
         blank = s_q.obe && !cur_sample[15] &&
            cur_sample >= GAPI_BLANK_LO && cur_sample <= GAPI_BLANK_HI;
         step = $signed({{(GAPI_FRAC_W+1){cur_sample[15]}}, cur_sample})
            + $signed({{(GAPI_FRAC_W+9){s_q.bias[7]}}, s_q.bias});
         if (blank) begin
            step = $signed({{(GAPI_FRAC_W+9){s_q.bias[7]}}, s_q.bias});
         end
         sum = 29'($signed({s_q.acc[15], s_q.acc, s_q.frac}) + step);
         sat_hi = !sum[28] && sum[27];
         sat_lo = sum[28] && !sum[27];
         if (sat_hi) begin
            s_d.acc = GAPI_ACC_MAX;
            s_d.frac = '0;
         end else if (sat_lo) begin
            s_d.acc = GAPI_ACC_MIN;
            s_d.frac = '1;
         end else begin
            s_d.acc = sum[27:GAPI_FRAC_W];
            s_d.frac = sum[GAPI_FRAC_W-1:0];
         end
      end
      diff = s_d.acc - s_q.acc_bak;
      if ($signed(diff) >= $signed(GAPI_BACKUP_STEP) ||
         $signed(diff) <= -$signed(GAPI_BACKUP_STEP)) begin
         s_d.copy = 1'b1;
         s_d.acc_bak = s_d.acc;
      end
      // results
      if (volt_tick && s_q.pm == GAPI_PM_ACTIVE && !s_q.frz) begin
         s_d.volt = volt_sample[15] ? GAPI_VOLT_MAX : volt_sample;
      end
      if (temp_tick && s_q.pm == GAPI_PM_ACTIVE) begin
         s_d.temp = temp_sample;
      end
      // power modes
      if (sleep_req) begin
         s_d.pm = GAPI_PM_SLEEP;
      end else if (suspend_req && s_q.sif != 2'b00) begin
         if (s_q.pm != GAPI_PM_SUSPEND) begin
            s_d.prog_io_pin_bit = 1'b1;
         end
         s_d.pm = GAPI_PM_SUSPEND;
      end else if (s_q.pm == GAPI_PM_SLEEP) begin
         s_d.pm = GAPI_PM_WAKE;
      end else begin
         s_d.pm = GAPI_PM_ACTIVE;
      end
      if (s_q.pm == GAPI_PM_WAKE) begin
         s_d.bias = nv_bias;
      end
      // long low on data line
      s_d.low_cnt = dq_s ? 32'h0 : s_q.low_cnt + {31'h0, !s_q.long_low};
      s_d.long_low = !dq_s && (s_q.low_cnt >= 32'(SLEEP_CYC - 1));
      if (s_q.pm == GAPI_PM_SLEEP || s_q.long_low) begin
         s_d.prog_io_pin_bit = 1'b1;
      end
      // suspend interrupt fires when woken by suspend_req dropping
      if (s_q.pm == GAPI_PM_SUSPEND && !suspend_req && !sleep_req) begin
         s_d.prog_io_pin_bit = 1'b0;
      end
      // alarm comparators
      alarm = ($signed(s_q.acc) >= $signed(s_q.acc_thr_hi)) ||
         ($signed(s_q.acc) <= $signed(s_q.acc_thr_lo)) ||
         ($signed(s_q.temp) >= $signed(s_q.tmp_thr_hi)) ||
         ($signed(s_q.temp) <= $signed(s_q.tmp_thr_lo));
      s_d.alarm_prev = alarm;
      if (alarm && !s_q.alarm_prev && s_q.ale && s_q.sif == 2'b00) begin
         if (s_q.irq_output_select) begin
            s_d.dq_cnt = 32'(ALARM_LOW_CYC);
         end else begin
            s_d.prog_io_pin_bit = 1'b0;
         end
      end
      if (s_q.dq_cnt != 32'h0) begin
         s_d.dq_cnt = s_q.dq_cnt - 32'h1;
      end
      s_d.dq_drv = (s_d.dq_cnt != 32'h0);
      // register writes; set by host after internal events
      if (wr) begin
         unique case (bus_req.address)
            GAPI_OFS_STATUS: begin
               s_d.obe = wd[GAPI_ST_OBE];
               s_d.irq_output_select = wd[GAPI_ST_IOS];
               s_d.sif = wd[GAPI_ST_SIF+:2];
            end
            GAPI_OFS_SPECIAL: begin
               s_d.ale = wd[GAPI_SF_ALE];
               if (!wd[GAPI_SF_FRZ]) s_d.frz = 1'b0;
               s_d.prog_io_pin_bit = wd[GAPI_SF_PIO];
            end
            GAPI_OFS_ACC: begin
               s_d.acc = wd[15:0];
               acc_wr = 1'b1;
            end
            GAPI_OFS_ACC_HI: s_d.acc_hi_pend = wd[7:0];
            GAPI_OFS_ACC_LO: begin
               s_d.acc = {s_q.acc_hi_pend, wd[7:0]};
               acc_wr = 1'b1;
            end
            GAPI_OFS_BIAS: s_d.bias = wd[7:0];
            GAPI_OFS_TEMP_HI: s_d.tmp_thr_hi = wd[10:0];
            GAPI_OFS_TEMP_LO: s_d.tmp_thr_lo = wd[10:0];
            GAPI_OFS_CMD: begin
               if (wd[GAPI_CMD_RECALL]) begin
                  s_d.acc = nv_acc;
                  s_d.acc_bak = nv_acc;
                  s_d.frac = '0;
               end
               if (wd[GAPI_CMD_FREEZE_HOLD_FLAG]) begin
                  s_d.volt = volt_sample[15] ? GAPI_VOLT_MAX : volt_sample;
                  s_d.frz = 1'b1;
               end
            end
            GAPI_OFS_NV: begin
               s_d.acc_thr_hi = wd[15:0];
               s_d.acc_thr_lo = wd[31:16];
            end
            default: ;
         endcase
      end
      if (acc_wr) begin
         s_d.frac = '0;
         s_d.copy = 1'b1;
         s_d.acc_bak = s_d.acc;
      end
      if (bus_reset) begin
         s_d.ale = 1'b0;
      end
      // read mux
      s_d.rdata = 32'h0;
      if (rd) begin
         unique case (bus_req.address)
            GAPI_OFS_STATUS: s_d.rdata = {27'h0, s_q.sif, s_q.irq_output_select, s_q.obe};
            GAPI_OFS_SPECIAL: s_d.rdata = {25'h0, pin_s, 4'h0, s_q.frz,
               s_q.ale};
            GAPI_OFS_VOLT: s_d.rdata = {16'h0, s_q.volt};
            GAPI_OFS_TEMP: s_d.rdata = {21'h0, s_q.temp};
            GAPI_OFS_ACC: s_d.rdata = {16'h0, s_q.acc};
            GAPI_OFS_BIAS: s_d.rdata = {24'h0, s_q.bias};
            GAPI_OFS_ACC_HI: s_d.rdata = {24'h0, s_q.acc[15:8]};
            GAPI_OFS_ACC_LO: s_d.rdata = {24'h0, s_q.acc[7:0]};
            GAPI_OFS_TEMP_HI: s_d.rdata = {21'h0, s_q.tmp_thr_hi};
            GAPI_OFS_TEMP_LO: s_d.rdata = {21'h0, s_q.tmp_thr_lo};
            GAPI_OFS_NV: s_d.rdata = {s_q.acc_thr_lo, s_q.acc_thr_hi};
            default: s_d.rdata = 32'h0;
         endcase
      end
      s_d.wait_n = (bus_req.read || bus_req.write) && !s_q.wait_n;
      // pin driver: off in suspend and sleep; gpio per control bit otherwise
      s_d.pin_oe_n = s_d.prog_io_pin_bit || s_d.pm == GAPI_PM_SUSPEND ||
         s_d.pm == GAPI_PM_SLEEP;
   end

   // ==========================================
   // registers; power-up restores from nonvolatile copy after release
   logic boot_q;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.pm <= GAPI_PM_ACTIVE;
         s_q.prog_io_pin_bit <= 1'b1;
         s_q.pin_oe_n <= 1'b1;
         s_q.acc_thr_hi <= GAPI_ACC_MAX;
         s_q.acc_thr_lo <= GAPI_ACC_MIN;
         s_q.tmp_thr_hi <= 11'h3ff;
         s_q.tmp_thr_lo <= 11'h400;
         s_q.bias <= GAPI_BIAS_RST;
         s_q.acc <= GAPI_ACC_RST;
         boot_q <= 1'b1;
      end else begin
         boot_q <= 1'b0;
         s_q <= s_d;
         if (boot_q) begin
            s_q.acc <= nv_acc;
            s_q.acc_bak <= nv_acc;
            s_q.bias <= nv_bias;
         end
      end
   end

   assign bus_rsp.readdata = s_q.rdata;
   assign bus_rsp.waitrequest = !s_q.wait_n;
   assign nv_acc_copy = s_q.copy;
   assign nv_acc_data = s_q.acc_bak;
   assign prog_pin_oe_n = s_q.pin_oe_n;
   assign data_line_oe_n = !s_q.dq_drv;
endmodule // gapi_top
`default_nettype wire

/* tb/gapi_checker_assertions.sv */
// concurrent checks on the gauge core ports
`timescale 1ns/1ns
`default_nettype none
module gapi_checker
   import gapi_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register bus
   input wire gapi_pkg::gapi_bus_req_t bus_req,
   input wire gapi_pkg::gapi_bus_rsp_t bus_rsp,
   // power and store
   input wire logic suspend_req,
   input wire logic sleep_req,
   input wire logic nv_acc_copy,
   // pin
   input wire logic prog_pin_oe_n
);
   // ==========================================
   // helpers
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic req, ok, wr_sf, wr_lo;
   assign req = bus_req.read | bus_req.write;
   assign ok = req & ~bus_rsp.waitrequest & bus_req.write;
   assign wr_sf = ok & (bus_req.address == GAPI_OFS_SPECIAL);
   assign wr_lo = ok & (bus_req.address == GAPI_OFS_ACC_LO);
   // ==========================================
   // bus handshake
   answer_next_a: assert property (
      req && bus_rsp.waitrequest |=> !bus_rsp.waitrequest)
      else $error("no answer one cycle after request");
   answer_once_a: assert property (!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
      else $error("answer stood longer than one cycle");
   idle_quiet_a: assert property (
      !req && bus_rsp.waitrequest |=> bus_rsp.waitrequest)
      else $error("answer without request");
   // ==========================================
   // pin driver
   pio_low_a: assert property (
      wr_sf && !bus_req.writedata[6] && !sleep_req && !suspend_req
      |-> ##[1:3] !prog_pin_oe_n) else $error("pin not pulled low");
   pio_float_a: assert property (
      wr_sf && bus_req.writedata[6] |-> ##[1:3] prog_pin_oe_n)
      else $error("pin not released");
   sleep_release_a: assert property (sleep_req [*4] |-> prog_pin_oe_n)
      else $error("pin driven in sleep");
   suspend_off_a: assert property (suspend_req [*4] |-> prog_pin_oe_n)
      else $error("pin driven in suspend");
   // ==========================================
   // nonvolatile copy; a pulse, so back-to-back highs are a stuck strobe
   write_copy_a: assert property (wr_lo |-> ##[1:4] nv_acc_copy)
      else $error("no copy after accumulator write");
   copy_pulse_a: assert property (nv_acc_copy |=> !nv_acc_copy)
      else $error("copy strobe longer than one cycle");
endmodule // gapi_checker
bind gapi_top gapi_checker chk (.ref_clk(ref_clk), .rst(rst),
   .bus_req(bus_req), .bus_rsp(bus_rsp), .suspend_req(suspend_req),
   .sleep_req(sleep_req), .nv_acc_copy(nv_acc_copy),
   .prog_pin_oe_n(prog_pin_oe_n));
`default_nettype wire

/* tb/gapi_host_model.sv */
// far-side model: pull-ups on the pin and data line, host can hold low
`timescale 1ns/1ns
`default_nettype none
module gapi_host_model (
   // enables from the block
   input wire logic prog_pin_oe_n,
   input wire logic data_line_oe_n,
   // host holds
   input wire logic host_pin_low,
   input wire logic host_line_low,
   // resolved wire levels
   output logic prog_pin_lvl,
   output logic data_line_lvl
);
   // ==========================================
   // wired-and: pulled high unless some party sinks it
   assign prog_pin_lvl = prog_pin_oe_n & ~host_pin_low;
   assign data_line_lvl = data_line_oe_n & ~host_line_low;
endmodule // gapi_host_model
`default_nettype wire

/* tb/gapi_top_tb_top.sv */
// self-checking bench of the gauge core
`timescale 1ns/1ns
`default_nettype none
module gapi_top_tb_top;
   import gapi_pkg::*;
   logic ref_clk, rst, suspend_req, sleep_req, bus_reset, nv_acc_copy;
   logic hp_low, hl_low, pin_lvl, line_lvl, pin_oe_n, line_oe_n;
   logic [15:0] cur_sample, volt_sample, nv_acc, nv_acc_data, v, x;
   logic [10:0] temp_sample;
   logic [7:0] nv_bias;
   gapi_bus_req_t bus_req;
   gapi_bus_rsp_t bus_rsp;
   int n_errors = 0, compares = 0, cyc = 0;
   logic [31:0] rq_exp[$], rq_msk[$];
   logic [15:0] cq[$];
   // ==========================================
   // design and far side
   gapi_top #(.SAMP_CYC(10), .VOLT_CYC(20), .TEMP_CYC(30),
      .ALARM_LOW_CYC(5), .SLEEP_CYC(50)) dut (.ref_clk(ref_clk), .rst(rst),
      .bus_req(bus_req), .bus_rsp(bus_rsp), .cur_sample(cur_sample),
      .volt_sample(volt_sample), .temp_sample(temp_sample), .nv_acc(nv_acc),
      .nv_bias(nv_bias), .nv_acc_copy(nv_acc_copy), .nv_acc_data(nv_acc_data),
      .suspend_req(suspend_req), .sleep_req(sleep_req),
      .bus_reset(bus_reset), .prog_pin_in(pin_lvl), .prog_pin_oe_n(pin_oe_n),
      .data_line_in(line_lvl), .data_line_oe_n(line_oe_n));
   gapi_host_model host (.prog_pin_oe_n(pin_oe_n), .data_line_oe_n(line_oe_n),
      .host_pin_low(hp_low), .host_line_low(hl_low), .prog_pin_lvl(pin_lvl),
      .data_line_lvl(line_lvl));
   // ==========================================
   // tasks
   task automatic give_verdict;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, e, m, input string s);
      compares++;
      if ((got & m) !== (e & m)) begin
         n_errors++;
         $display("mismatch %0t %s got %h exp %h", $time, s, got, e);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // holds the request until waitrequest is seen low, then one idle edge
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int t;
      logic ws;
      t = 0;
      bus_req <= '{address: a, read: ~w, write: w, writedata: d};
      do begin
         @(negedge ref_clk);
         ws = bus_rsp.waitrequest;
         @(posedge ref_clk);
         t++;
      end while (ws !== 1'b0 && t < 100);
      bus_req <= '0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e, m);
      rq_exp.push_back(e);
      rq_msk.push_back(m);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic wacc(input logic [15:0] a);
      cq.push_back(a);
      bus(1'b1, GAPI_OFS_ACC_HI, {24'h0, a[15:8]});
      bus(1'b1, GAPI_OFS_ACC_LO, {24'h0, a[7:0]});
   endtask
   // ==========================================
   // clock, watchdog and result watchers
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 95000) begin
         n_errors++;
         give_verdict();
      end
   end
   // outputs looked at mid-cycle, where they have settled
   always @(negedge ref_clk) begin
      if (bus_req.read && bus_rsp.waitrequest === 1'b0 && rq_exp.size() > 0)
         cmp(bus_rsp.readdata, rq_exp.pop_front(), rq_msk.pop_front(), "read");
      // copies nobody asked for are backups we do not track
      if (nv_acc_copy === 1'b1 && cq.size() > 0)
         cmp({16'h0, nv_acc_data}, {16'h0, cq.pop_front()}, 32'hffff, "copy");
   end
   // ==========================================
   // scenarios
   initial begin
      v = $urandom(80336);
      rst = 1'b1;
      bus_req = '0;
      cur_sample = 16'h0;
      volt_sample = 16'h0;
      temp_sample = 11'($urandom);
      nv_acc = 16'($urandom);
      nv_bias = 8'($urandom) & 8'h0f;
      {suspend_req, sleep_req, bus_reset, hp_low, hl_low} = 5'h0;
      wt(12);
      rst <= 1'b0;
      wt(2);
      rd(GAPI_OFS_ACC, {16'h0, nv_acc}, 32'hffff);
      rd(GAPI_OFS_BIAS, {24'h0, nv_bias}, 32'hff);
      x = 16'($urandom) & 16'h0fff;
      wacc(x);
      rd(GAPI_OFS_ACC, {16'h0, x}, 32'hffff);
      bus(1'b1, GAPI_OFS_CMD, 32'h1);
      rd(GAPI_OFS_ACC, {16'h0, nv_acc}, 32'hffff);
      bus(1'b1, 6'h30, 32'hffffffff);
      rd(6'h30, 32'h0, 32'hffffffff);
      // saturation both ways
      wacc(16'h7ff0);
      cur_sample <= 16'h7fff;
      wt(300);
      rd(GAPI_OFS_ACC, 32'h7fff, 32'hffff);
      wacc(16'h8010);
      cur_sample <= 16'h8000;
      wt(300);
      rd(GAPI_OFS_ACC, 32'h8000, 32'hffff);
      // automatic backup one step above the written value
      cur_sample <= 16'h0;
      wacc(x);
      cq.push_back(x + GAPI_BACKUP_STEP);
      cur_sample <= 16'h0040;
      for (int i = 0; i < 60000 && cq.size() > 0; i++)
         wt(1);
      cmp(32'(cq.size()), 32'h0, 32'hffffffff, "copy missing");
      cur_sample <= 16'h0;
      // pin as output and input
      // pin level passes two sync flops before it can be read back
      bus(1'b1, GAPI_OFS_SPECIAL, 32'h0);
      wt(2);
      rd(GAPI_OFS_SPECIAL, 32'h0, 32'h40);
      bus(1'b1, GAPI_OFS_SPECIAL, 32'h40);
      wt(2);
      rd(GAPI_OFS_SPECIAL, 32'h40, 32'h40);
      hp_low <= 1'b1;
      wt(4);
      rd(GAPI_OFS_SPECIAL, 32'h0, 32'h40);
      hp_low <= 1'b0;
      // bus reset drops the alarm enable
      bus(1'b1, GAPI_OFS_SPECIAL, 32'h41);
      rd(GAPI_OFS_SPECIAL, 32'h1, 32'h1);
      bus_reset <= 1'b1;
      wt(1);
      bus_reset <= 1'b0;
      rd(GAPI_OFS_SPECIAL, 32'h0, 32'h1);
      // voltage, its ceiling and the frozen sample
      v = 16'($urandom) & 16'h7fff;
      volt_sample <= v;
      wt(50);
      rd(GAPI_OFS_VOLT, {16'h0, v}, 32'hffff);
      volt_sample <= 16'hc000;
      wt(50);
      rd(GAPI_OFS_VOLT, 32'h7fff, 32'hffff);
      volt_sample <= v;
      wt(50);
      bus(1'b1, GAPI_OFS_CMD, 32'h2);
      wt(25);
      volt_sample <= ~v & 16'h7fff;
      wt(50);
      rd(GAPI_OFS_VOLT, {16'h0, v}, 32'hffff);
      bus(1'b1, GAPI_OFS_SPECIAL, 32'h40);
      wt(50);
      rd(GAPI_OFS_VOLT, {16'h0, ~v & 16'h7fff}, 32'hffff);
      // sleep releases the pin and reloads the bias on wake
      bus(1'b1, GAPI_OFS_BIAS, 32'h55);
      bus(1'b1, GAPI_OFS_SPECIAL, 32'h0);
      sleep_req <= 1'b1;
      wt(10);
      cmp({31'h0, pin_lvl}, 32'h1, 32'h1, "sleep pin");
      sleep_req <= 1'b0;
      wt(10);
      rd(GAPI_OFS_SPECIAL, 32'h40, 32'h40);
      rd(GAPI_OFS_BIAS, {24'h0, nv_bias}, 32'hff);
      // suspend: pending pin low cleared, then interrupt on wake
      bus(1'b1, GAPI_OFS_STATUS, 32'h4);
      bus(1'b1, GAPI_OFS_SPECIAL, 32'h0);
      suspend_req <= 1'b1;
      wt(10);
      cmp({31'h0, pin_lvl}, 32'h1, 32'h1, "suspend pin");
      suspend_req <= 1'b0;
      wt(10);
      cmp({31'h0, pin_lvl}, 32'h0, 32'h1, "suspend irq");
      rd(GAPI_OFS_SPECIAL, 32'h0, 32'h40);
      bus(1'b1, GAPI_OFS_SPECIAL, 32'h40);
      wt(3);
      cmp({31'h0, pin_lvl}, 32'h1, 32'h1, "irq cleared");
      wt(5);
      give_verdict();
   end
endmodule // gapi_top_tb_top
`default_nettype wire
